/* hw/sppd_dev.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: twelve word buffer per stereo pair stream
// R2: pairs run independently, no interleaved packing
// R3: burst size eight leaves only digital pair
// R4: digital out channel always independently controllable
// R5: smaller multichannel burst frees pair channels
// R6: every transfer is one 32 bit word
// R7: samples msb aligned, unused bits at bottom
// R8: one request gives exactly one burst
// R9: burst is eight words, four stereo periods
// R10: samples to digital out and serial copy
// R11: base written in words, read gives current
// R12: two low address bits read zero
// R13: software programs size in words minus one
// R14: count decrements, reloads size at zero
// R15: count read returns current position
// R16: terminal count decrements, interrupts at zero
// R17: software programs interval in words minus one
// R18: address and count reset to zero
// R19: request only with room for whole burst
// R20: count reload returns address to base
// R21: terminal count reloads after interrupt
module sppd_dev #(
    parameter int DEPTH = sppd_pkg::BUF_DEPTH,  // stream buffer words
    parameter int BURST = sppd_pkg::BURST_LEN   // words per burst
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        ce,
    sppd_if.dev              bus,
    input  wire logic        run,
    input  wire logic [3:0]  multi_burst,
    input  wire logic        sample_req,
    output logic [31:0]      dig_out_left,
    output logic [31:0]      dig_out_right,
    output logic             dig_out_valid,
    output logic             underrun,
    output logic             irq,
    output logic             pair_avail,
    output logic             fourth_serial_audio_out,
    output logic             serial_bclk,
    output logic             serial_ws
);
    localparam int PW = $clog2(DEPTH);      // pointer width
    localparam int CW = $clog2(DEPTH + 1);  // fill counter width

    // whole state of the channel
    typedef struct packed {
        sppd_pkg::sppd_fetch_t st;          // fetch sequencer
        logic [29:0]           base_addr;   // programmed base, words
        logic [29:0]           cur_addr;    // current address, words
        logic [29:0]           burst_addr;  // start of open burst
        logic [15:0]           base_cnt;    // programmed size
        logic [15:0]           cur_cnt;     // position counter
        logic [15:0]           base_tc;     // programmed interval
        logic [15:0]           cur_tc;      // interval counter
        logic [DEPTH-1:0][31:0] mem;        // stream buffer
        logic [PW-1:0]         wp;          // write pointer
        logic [PW-1:0]         rp;          // read pointer
        logic [CW-1:0]         fill;        // words held
        logic [3:0]            beats;       // words of open burst
        logic                  req;         // burst request
        logic [31:0]           rdata;       // register read data
        logic                  rvalid;      // read data strobe
        logic [31:0]           left;        // last left sample
        logic [31:0]           right;       // last right sample
        logic                  valid;       // sample pair strobe
        logic                  under;       // underrun strobe
        logic                  irq;         // interrupt strobe
        logic                  avail;       // pair channels free
        logic [63:0]           sh;          // serial shifter
        logic [6:0]            bitn;        // serial bit index
        logic                  bclk;        // serial bit clock
        logic                  ws;          // serial word select
        logic                  sd;          // serial data
        logic                  busy;        // serial frame active
    } sppd_dev_st_t;

    sppd_dev_st_t r;    // registered state
    sppd_dev_st_t nxt;  // next state

    // next pointer with wrap at buffer end
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    logic push;  // data phase accepted
    logic pop;   // sample pair taken

    // next-state logic
    always_comb begin
        nxt        = r;
        nxt.rvalid = 1'b0;
        nxt.valid  = 1'b0;
        nxt.under  = 1'b0;
        nxt.irq    = 1'b0;
        push       = bus.m_valid && (r.st == sppd_pkg::SPPD_DATA);
        pop        = sample_req && (r.fill >= CW'(2));

        // word arrives from a burst
        if (push) begin
            nxt.mem[r.wp] = bus.m_data;  // R6 R7
            nxt.wp        = ptr_inc(r.wp);
            nxt.fill      = nxt.fill + CW'(1);
            nxt.beats     = r.beats + 4'h1;
            if (r.cur_cnt == 16'h0000) begin
                nxt.cur_cnt  = r.base_cnt;   // R14
                nxt.cur_addr = r.base_addr;  // R20
            end else begin
                nxt.cur_cnt  = r.cur_cnt - 16'h0001;  // R14
                nxt.cur_addr = r.cur_addr + 30'h0000_0001;
            end
            if (r.cur_tc == 16'h0000) begin
                nxt.irq    = 1'b1;       // R16
                nxt.cur_tc = r.base_tc;  // R21
            end else begin
                nxt.cur_tc = r.cur_tc - 16'h0001;  // R16
            end
        end

        // stereo pair leaves to transmitter and serial copy
        if (pop) begin
            nxt.left  = r.mem[r.rp];           // R10
            nxt.right = r.mem[ptr_inc(r.rp)];  // R10
            nxt.valid = 1'b1;
            nxt.rp    = ptr_inc(ptr_inc(r.rp));
            nxt.fill  = nxt.fill - CW'(2);
            nxt.sh    = {r.mem[r.rp], r.mem[ptr_inc(r.rp)]};
            nxt.sd    = r.mem[r.rp][31];
            nxt.bitn  = 7'h00;
            nxt.ws    = 1'b0;
            nxt.bclk  = 1'b0;
            nxt.busy  = 1'b1;
        end else if (sample_req) begin
            nxt.under = 1'b1;  // buffer ran dry
        end

        // serial shifter, data moves on falling bit clock
        if (!pop && r.busy) begin
            nxt.bclk = ~r.bclk;
            if (r.bclk) begin
                if (r.bitn == 7'(sppd_pkg::FRAME_BITS - 1)) begin
                    nxt.busy = 1'b0;  // frame done
                    nxt.bclk = 1'b0;
                end else begin
                    nxt.bitn = r.bitn + 7'h01;
                    nxt.sh   = {r.sh[62:0], 1'b0};
                    nxt.sd   = r.sh[62];  // R10
                    // select flips one bit ahead of each slot
                    nxt.ws   = (nxt.bitn >= 7'(sppd_pkg::SLOT_BITS - 1))
                            && (nxt.bitn < 7'(sppd_pkg::FRAME_BITS - 1));
                end
            end
        end

        // fetch sequencer
        case (r.st)
            sppd_pkg::SPPD_IDLE: begin
                // no refill until a whole burst fits
                if (run && r.fill <= CW'(DEPTH - BURST)) begin  // R19 R1
                    nxt.st         = sppd_pkg::SPPD_REQ;
                    nxt.req        = 1'b1;
                    nxt.burst_addr = r.cur_addr;
                end
            end
            sppd_pkg::SPPD_REQ: begin
                // one grant opens exactly one burst
                if (bus.m_gnt) begin  // R8
                    nxt.req   = 1'b0;
                    nxt.st    = sppd_pkg::SPPD_DATA;
                    nxt.beats = 4'h0;
                end
            end
            sppd_pkg::SPPD_DATA: begin
                // burst closes after its eighth word
                if (push && nxt.beats == 4'(BURST)) begin  // R9
                    nxt.st = sppd_pkg::SPPD_IDLE;
                end
            end
            default: begin
                nxt.st  = sppd_pkg::SPPD_IDLE;
                nxt.req = 1'b0;
            end
        endcase

        // software writes override the running counters
        if (bus.reg_wr) begin
            case (bus.reg_addr)
                sppd_pkg::ADDR_OFF: begin
                    // low two bits dropped, word units only
                    nxt.base_addr = bus.reg_wdata[31:sppd_pkg::ADDR_LSB];
                    nxt.cur_addr  = bus.reg_wdata[31:sppd_pkg::ADDR_LSB];
                end  // R11 R12
                sppd_pkg::COUNT_OFF: begin
                    nxt.base_cnt = bus.reg_wdata[sppd_pkg::HALF_W-1:0];
                    nxt.cur_cnt  = bus.reg_wdata[sppd_pkg::HALF_W-1:0];
                end  // R13
                sppd_pkg::TC_OFF: begin
                    nxt.base_tc = bus.reg_wdata[sppd_pkg::HALF_W-1:0];
                    nxt.cur_tc  = bus.reg_wdata[sppd_pkg::HALF_W-1:0];
                end  // R17
                default: begin
                    // unmapped write ignored
                end
            endcase
        end

        // register reads return live address and count, zero elsewhere
        if (bus.reg_rd) begin
            nxt.rvalid = 1'b1;
            case (bus.reg_addr)
                sppd_pkg::ADDR_OFF:
                    nxt.rdata = {r.cur_addr, 2'h0};  // R11 R12
                sppd_pkg::COUNT_OFF:
                    nxt.rdata = {16'h0000, r.cur_cnt};  // R15
                default:
                    nxt.rdata = 32'h0000_0000;  // write-only, unmapped
            endcase
        end

        // pair channels exist only below the full burst
        nxt.avail = (multi_burst < sppd_pkg::MC_FULL_BURST);  // R3 R5
    end

    // state register, frozen while ce low
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r           <= '0;
            r.st        <= sppd_pkg::SPPD_IDLE;
            r.base_addr <= sppd_pkg::ADDR_RST;   // R18
            r.cur_addr  <= sppd_pkg::ADDR_RST;   // R18
            r.base_cnt  <= sppd_pkg::COUNT_RST;  // R18
            r.cur_cnt   <= sppd_pkg::COUNT_RST;  // R18
            r.base_tc   <= sppd_pkg::TC_RST;
            r.cur_tc    <= sppd_pkg::TC_RST;
        end else if (ce) begin
            r <= nxt;
        end
    end

    // outputs straight from state flops
    assign bus.reg_rdata           = r.rdata;
    assign bus.reg_rvalid          = r.rvalid;
    assign bus.m_req               = r.req;
    assign bus.m_addr              = {r.burst_addr, 2'h0};
    assign dig_out_left            = r.left;   // R2 R4
    assign dig_out_right           = r.right;
    assign dig_out_valid           = r.valid;
    assign underrun                = r.under;
    assign irq                     = r.irq;
    assign pair_avail              = r.avail;
    assign fourth_serial_audio_out = r.sd;
    assign serial_bclk             = r.bclk;
    assign serial_ws               = r.ws;

endmodule : sppd_dev

/* hw/sppd_pkg.sv */
package sppd_pkg;

    // register offsets, byte addresses on the register port
    localparam logic [7:0]  ADDR_OFF     = 8'h40;  // address base/current
    localparam logic [7:0]  COUNT_OFF    = 8'h44;  // buffer size/position
    localparam logic [7:0]  TC_OFF       = 8'h46;  // terminal count
    // field positions
    localparam int          ADDR_LSB     = 2;      // word address lsb
    localparam int          HALF_W       = 16;     // count field width
    // reset values
    localparam logic [29:0] ADDR_RST     = 30'h0000_0000;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    localparam logic [15:0] TC_RST       = 16'h0000;
    // geometry
    localparam int          BUF_DEPTH    = 12;     // stream buffer words
    localparam int          BURST_LEN    = 8;      // data phases per burst
    localparam int          WORD_W       = 32;     // transfer width
    localparam logic [3:0]  MC_FULL_BURST = 4'h8;  // multichannel default
    localparam int          FRAME_BITS   = 64;     // serial bits per pair
    localparam int          SLOT_BITS    = 32;     // serial bits per slot

    // fetch sequencer states, one-hot
    typedef enum logic [2:0] {
        SPPD_IDLE = 3'h1,
        SPPD_REQ  = 3'h2,
        SPPD_DATA = 3'h4
    } sppd_fetch_t;

    // host burst server states, one-hot
    typedef enum logic [2:0] {
        SPPD_H_IDLE  = 3'h1,
        SPPD_H_READ  = 3'h2,
        SPPD_H_DRAIN = 3'h4
    } sppd_serve_t;

endpackage : sppd_pkg

/* hw/sppd_if.sv */
`timescale 1ns/1ps
interface sppd_if;
    logic        reg_wr;     // register write strobe
    logic        reg_rd;     // register read strobe
    logic [7:0]  reg_addr;   // register byte offset
    logic [31:0] reg_wdata;  // write data
    logic [31:0] reg_rdata;  // read data
    logic        reg_rvalid; // read data valid
    logic        m_req;      // burst request level
    logic [31:0] m_addr;     // burst start byte address
    logic        m_gnt;      // burst accepted pulse
    logic        m_valid;    // data phase strobe
    logic [31:0] m_data;     // data phase word

    // documented device end
    modport dev (
        input  reg_wr,
        input  reg_rd,
        input  reg_addr,
        input  reg_wdata,
        output reg_rdata,
        output reg_rvalid,
        output m_req,
        output m_addr,
        input  m_gnt,
        input  m_valid,
        input  m_data
    );

    // host and memory end
    modport host (
        output reg_wr,
        output reg_rd,
        output reg_addr,
        output reg_wdata,
        input  reg_rdata,
        input  reg_rvalid,
        input  m_req,
        input  m_addr,
        output m_gnt,
        output m_valid,
        output m_data
    );
endinterface : sppd_if

/* hw/sppd_host.sv */
`timescale 1ns/1ps
module sppd_host #(
    parameter int BURST = sppd_pkg::BURST_LEN  // words per burst
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        ce,
    sppd_if.host             bus,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_rvalid,
    output logic             mem_rd,
    output logic [31:0]      mem_addr,
    input  wire logic [31:0] mem_rdata
);
    // whole state of the host end
    typedef struct packed {
        sppd_pkg::sppd_serve_t st;    // burst server
        logic [3:0]            left;  // reads still to issue
        logic                  wr;    // register write strobe
        logic                  rd;    // register read strobe
        logic [7:0]            addr;  // register offset
        logic [31:0]           wdat;  // register write data
        logic [31:0]           rdat;  // captured read data
        logic                  rval;  // read data strobe
        logic                  gnt;   // burst grant pulse
        logic                  mrd;   // memory read strobe
        logic [31:0]           maddr; // memory byte address
        logic                  mval;  // data phase strobe
        logic [31:0]           mdat;  // data phase word
    } sppd_host_st_t;

    sppd_host_st_t r;    // registered state
    sppd_host_st_t nxt;  // next state

    // next-state logic
    always_comb begin
        nxt      = r;
        nxt.gnt  = 1'b0;
        nxt.mrd  = 1'b0;
        // software access passes through one stage
        nxt.wr   = cfg_wr;    // R13 R17
        nxt.rd   = cfg_rd;
        nxt.addr = cfg_addr;
        nxt.wdat = cfg_wdata; // R11
        nxt.rval = bus.reg_rvalid;
        if (bus.reg_rvalid) begin
            nxt.rdat = bus.reg_rdata;
        end
        // memory word returns one cycle after its read, unchanged
        nxt.mval = r.mrd;
        nxt.mdat = mem_rdata;  // R7

        case (r.st)
            sppd_pkg::SPPD_H_IDLE: begin
                // grant one request, serve one burst
                if (bus.m_req) begin  // R8
                    nxt.gnt   = 1'b1;
                    nxt.maddr = bus.m_addr;
                    nxt.left  = 4'(BURST);
                    nxt.st    = sppd_pkg::SPPD_H_READ;
                end
            end
            sppd_pkg::SPPD_H_READ: begin
                // eight consecutive word reads
                nxt.mrd  = 1'b1;  // R9
                nxt.left = r.left - 4'h1;
                if (r.mrd) begin
                    nxt.maddr = r.maddr + 32'h0000_0004;
                end
                if (r.left == 4'h1) begin
                    nxt.st = sppd_pkg::SPPD_H_DRAIN;
                end
            end
            sppd_pkg::SPPD_H_DRAIN: begin
                // last word leaves, requester has dropped
                nxt.st = sppd_pkg::SPPD_H_IDLE;
            end
            default: begin
                nxt.st = sppd_pkg::SPPD_H_IDLE;
            end
        endcase
    end

    // state register, frozen while ce low
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r    <= '0;
            r.st <= sppd_pkg::SPPD_H_IDLE;
        end else if (ce) begin
            r <= nxt;
        end
    end

    // outputs straight from state flops
    assign bus.reg_wr    = r.wr;
    assign bus.reg_rd    = r.rd;
    assign bus.reg_addr  = r.addr;
    assign bus.reg_wdata = r.wdat;
    assign bus.m_gnt     = r.gnt;
    assign bus.m_valid   = r.mval;
    assign bus.m_data    = r.mdat;
    assign cfg_rdata     = r.rdat;
    assign cfg_rvalid    = r.rval;
    assign mem_rd        = r.mrd;
    assign mem_addr      = r.maddr;

endmodule : sppd_host

/* verification/sppd_sva.sv */
`timescale 1ns/1ps
// protocol checker on the link between the device end and the host end
module sppd_sva (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        m_req,
    input wire logic [31:0] m_addr,
    input wire logic        m_gnt,
    input wire logic        m_valid,
    input wire logic [31:0] m_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // read data answers exactly one cycle after each read strobe
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe without answer");
    AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without strobe");
    // base written then read back with no word in between
    AST_BASE_BACK: assert property ((reg_wr && reg_addr == sppd_pkg::ADDR_OFF
        && !m_valid) ##1 !m_valid ##1 (reg_rd && !m_valid
        && reg_addr == sppd_pkg::ADDR_OFF) |=> reg_rdata ==
        {$past(reg_wdata[31:2], 3), 2'b00})
        else $error("address read back differs from base");
    AST_ADDR_LOW: assert property (reg_rd && reg_addr == sppd_pkg::ADDR_OFF
        |=> reg_rdata[1:0] == 2'b00)
        else $error("address low bits not zero");
    AST_COUNT_UPPER: assert property (reg_rd && reg_addr ==
        sppd_pkg::COUNT_OFF |=> reg_rdata[31:16] == 16'h0000)
        else $error("count read upper half not zero");
    // write-only and unmapped places read zero
    AST_WO_ZERO: assert property (reg_rd && reg_addr != sppd_pkg::ADDR_OFF
        && reg_addr != sppd_pkg::COUNT_OFF |=> reg_rdata == 32'h0000_0000)
        else $error("write-only or unmapped read not zero");
    // one request, one grant, one burst
    AST_GNT_NEXT: assert property ($rose(m_req) |=> m_gnt)
        else $error("request not granted next cycle");
    AST_REQ_HOLD: assert property (m_req && !m_gnt
        |=> m_req && $stable(m_addr))
        else $error("request dropped or address moved before grant");
    AST_ONE_BURST: assert property (m_gnt |=> !m_req ##1 (!m_gnt) [*8])
        else $error("request kept or second grant inside burst");
    AST_BURST_LEN: assert property (m_gnt
        |-> ##2 m_valid [*8] ##1 !m_valid)
        else $error("burst not eight data phases");
    AST_VALID_CAUSE: assert property ($rose(m_valid) |-> $past(m_gnt, 2))
        else $error("data phase without grant");
    AST_ADDR_WORD: assert property (m_req |-> m_addr[1:0] == 2'b00)
        else $error("burst address not word aligned");
    AST_REQ_IDLE: assert property (m_valid |-> !m_req)
        else $error("request raised during a burst");

    // main scenarios
    COV_GRANT: cover property (m_gnt ##3 m_valid);
    COV_BURST: cover property (m_valid [*8]);
    COV_COUNT_RD: cover property (reg_rd && reg_addr == sppd_pkg::COUNT_OFF);
endmodule : sppd_sva

/* verification/stereo_pair_playback_dma_bench.sv */
`timescale 1ns/1ps
module stereo_pair_playback_dma_bench;
    localparam int N_W = 16;  // buffer size in words
    localparam int T_W = 8;   // interrupt interval in words
    logic        clock, arst_n, ce, run, sample_req;
    logic [3:0]  multi_burst;
    logic [31:0] dig_out_left, dig_out_right;
    logic        dig_out_valid, underrun, irq, pair_avail;
    logic        ser_data, serial_bclk, serial_ws;
    logic        cfg_wr, cfg_rd, cfg_rvalid, mem_rd;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, mem_addr, mem_rdata;
    logic [31:0] salt, base, rd_v;    // scrambler, byte base, last read
    logic [31:0] exp_q[$];            // fetched words awaiting output
    logic [31:0] last_l, last_r;      // pair last handed out
    logic [63:0] ser_sh;              // serial bits collected
    logic        req_q, bclk_q;       // previous-edge copies
    int          n_mismatch, n_checks, words, fill, n_irq, n_bits, n_rd;
    int          seed_v, gap, i;

    sppd_if bus_if ();
    sppd_dev u_sppd_dev (.clock (clock), .arst_n (arst_n), .ce (ce),
        .bus (bus_if), .run (run), .multi_burst (multi_burst),
        .sample_req (sample_req), .dig_out_left (dig_out_left),
        .dig_out_right (dig_out_right), .dig_out_valid (dig_out_valid),
        .underrun (underrun), .irq (irq), .pair_avail (pair_avail),
        .fourth_serial_audio_out (ser_data), .serial_bclk (serial_bclk),
        .serial_ws (serial_ws));
    sppd_host u_sppd_host (.clock (clock), .arst_n (arst_n), .ce (ce),
        .bus (bus_if), .cfg_wr (cfg_wr), .cfg_rd (cfg_rd),
        .cfg_addr (cfg_addr), .cfg_wdata (cfg_wdata),
        .cfg_rdata (cfg_rdata), .cfg_rvalid (cfg_rvalid),
        .mem_rd (mem_rd), .mem_addr (mem_addr), .mem_rdata (mem_rdata));
    sppd_sva u_sppd_sva (.clock (clock), .arst_n (arst_n),
        .reg_wr (bus_if.reg_wr), .reg_rd (bus_if.reg_rd),
        .reg_addr (bus_if.reg_addr), .reg_wdata (bus_if.reg_wdata),
        .reg_rdata (bus_if.reg_rdata), .reg_rvalid (bus_if.reg_rvalid),
        .m_req (bus_if.m_req), .m_addr (bus_if.m_addr),
        .m_gnt (bus_if.m_gnt), .m_valid (bus_if.m_valid),
        .m_data (bus_if.m_data));

    // memory content is the address scrambled, valid in the read cycle
    assign mem_rdata = mem_addr ^ salt;

    // clock at 40 MHz
    always #12.5 clock = ~clock;

    // byte address of the k-th word fetched, wrapping over the buffer
    function automatic logic [31:0] exp_addr(input int k);
        return base + 32'(4 * (k % N_W));
    endfunction : exp_addr

    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // one software write, strobe for one cycle
    task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cfg_wr    <= 1'b1;
        cfg_addr  <= a;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr    <= 1'b0;
    endtask : cfg_write

    // one software read, bounded wait for the answer
    task automatic cfg_read(input logic [7:0] a);
        int k;
        @(posedge clock);
        cfg_rd   <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd   <= 1'b0;
        for (k = 0; k < 10; k++) begin
            @(posedge clock);
            #1;
            if (cfg_rvalid === 1'b1) begin
                rd_v = cfg_rdata;
                return;
            end
        end
        n_mismatch++;
        complete_run();
    endtask : cfg_read

    // one pair request, sampled at the second edge
    task automatic pulse_sample;
        @(posedge clock);
        sample_req <= 1'b1;
        @(posedge clock);
        sample_req <= 1'b0;
    endtask : pulse_sample

    // scoreboard: burst addresses, fetched data, pairs and serial copy
    always @(posedge clock) begin
        if (arst_n) begin
            if (bus_if.m_req && !req_q) begin
                check(64'(bus_if.m_addr), 64'(exp_addr(words)));
                check(64'(fill <= 12 - 8), 64'(1));
            end
            if (bus_if.m_valid) begin
                check(64'(bus_if.m_data), 64'(exp_addr(words) ^ salt));
                exp_q.push_back(exp_addr(words) ^ salt);
                words++;
                fill++;
                check(64'(fill <= 12), 64'(1));
            end
            if (sample_req && fill >= 2) fill -= 2;
            if (irq) n_irq++;
            if (mem_rd) n_rd++;
            if (dig_out_valid) begin
                last_l = exp_q.pop_front();
                last_r = exp_q.pop_front();
                check(64'(dig_out_left), 64'(last_l));
                check(64'(dig_out_right), 64'(last_r));
                n_bits = 0;
            end else if (serial_bclk && !bclk_q) begin
                check(64'(serial_ws), 64'(n_bits inside {[31:62]}));
                ser_sh = {ser_sh[62:0], ser_data};
                n_bits++;
                if (n_bits == 64) check(ser_sh, {last_l, last_r});
            end
        end
        req_q  = bus_if.m_req;
        bclk_q = serial_bclk;
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end

    // main sequence
    initial begin
        clock = 1'b0; arst_n = 1'b0; ce = 1'b1; run = 1'b0;
        multi_burst = sppd_pkg::MC_FULL_BURST; sample_req = 1'b0;
        cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_addr = 8'h00;
        cfg_wdata = 32'h0000_0000; base = 32'h0000_0000;
        n_mismatch = 0; n_checks = 0; words = 0; fill = 0; n_irq = 0;
        n_bits = 0; req_q = 1'b0; bclk_q = 1'b0; ser_sh = 64'h0;
        seed_v = $urandom(32'hfc83);
        salt = $urandom;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        cfg_read(sppd_pkg::ADDR_OFF);
        check(64'(rd_v), 64'h0);
        cfg_read(sppd_pkg::COUNT_OFF);
        check(64'(rd_v), 64'h0);
        cfg_read(sppd_pkg::TC_OFF);
        check(64'(rd_v), 64'h0);
        cfg_read(8'h48);
        check(64'(rd_v), 64'h0);
        // every burst-size setting
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            multi_burst <= 4'(i);
            repeat (2) @(posedge clock);
            #1;
            check(64'(pair_avail), 64'(i < 8));
        end
        // full multichannel burst: digital pair must still stream
        @(posedge clock);
        multi_burst <= sppd_pkg::MC_FULL_BURST;
        pulse_sample();
        #1;
        check(64'(underrun), 64'h1);
        check(64'(dig_out_valid), 64'h0);
        base = $urandom & 32'h00FF_FFC0;
        cfg_write(sppd_pkg::ADDR_OFF, base | 32'h0000_0003);
        cfg_read(sppd_pkg::ADDR_OFF);
        check(64'(rd_v), 64'(base));
        cfg_write(sppd_pkg::COUNT_OFF, 32'(N_W - 1));
        cfg_write(sppd_pkg::TC_OFF, 32'(T_W - 1));
        cfg_read(sppd_pkg::COUNT_OFF);
        check(64'(rd_v), 64'(N_W - 1));
        @(posedge clock);
        run <= 1'b1;
        repeat (40) @(posedge clock);
        for (i = 0; i < 18 + int'($urandom_range(0, 8)); i++) begin
            pulse_sample();
            gap = 132 + int'($urandom_range(0, 24));
            repeat (gap) @(posedge clock);
        end
        run <= 1'b0;
        repeat (40) @(posedge clock);
        cfg_read(sppd_pkg::COUNT_OFF);
        check(64'(rd_v), 64'(N_W - 1 - words % N_W));
        cfg_read(sppd_pkg::ADDR_OFF);
        check(64'(rd_v), 64'(exp_addr(words)));
        check(64'(n_irq), 64'(words / T_W));
        check(64'(n_rd), 64'(words));
        complete_run();
    end
endmodule : stereo_pair_playback_dma_bench
